// [hdl/sfr_region_ctrl.sv]
// sfr_region_ctrl: serial flash and module controller with descriptor regions.
// Assumes ref_clk 100 MHz, io pins resolved outside from ioOe_n, pull-ups on io.
// How it works
// [RULE_01] Three low-active selects: two flash parts, third only for the module.
// [RULE_02] Three-byte parts hold 16 MB each, 32 MB across both.
// [RULE_03] Four-byte parts hold 64 MB each, 128 MB across both.
// [RULE_04] Address width per part comes from its discovery table at boot.
// [RULE_05] Serial clock at one of 14, 25, 33, 50 or 100 MHz settings; the code runs them at 12.5, 25, 25, 25 and 25 MHz.
// [RULE_06] Dual out, dual io, quad out and quad io fast reads.
// [RULE_07] Module reads share clock and data lines, only the select differs.
// [RULE_08] Descriptor mode only; without valid descriptor flash reads are refused.
// [RULE_09] Regions: 0 descriptor, 1 boot, 2 engine, 3 network, 4 platform, 8 EC, 10 security.
// [RULE_10] Exactly four requesters may reach regions.
// [RULE_11] Image holds descriptor at offset 0 of part 0 and engine region.
// [RULE_12] Region positions come from the descriptor, in any order.
// [RULE_13] A contiguous region may span both parts as one linear space.
// [RULE_14] Image gives descriptor one erase block, network region two.
// [RULE_15] Region sizes follow erase block size of 4, 8 or 64 KB.
// [RULE_16] A discoverable flash with descriptor sits on the primary select.
// [RULE_17] Descriptor valid only when word at 0x10 matches the signature.
// [RULE_18] Only the first 4 KB of the descriptor block is used.
// [RULE_19] Each requester reads directly only its own primary region.
// [RULE_20] One select at a time; clock idle low while none is active.
// [RULE_21] Linear address checked against region base and limit, else refused.
`timescale 1ns/10ps
module sfr_region_ctrl (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  output logic             serialFlashClock,
  output logic             flashSelectPrimary_n,
  output logic             flashSelectSecondary_n,
  output logic             moduleSelect_n,
  input  wire logic [3:0]  ioIn,
  output logic      [3:0]  ioOut,
  output logic      [3:0]  ioOe_n,
  input  wire logic [2:0]  rateSel,
  input  wire logic [2:0]  readMode,
  input  wire logic        reqValid,
  output logic             reqReady,
  input  wire logic [1:0]  reqId,
  input  wire logic        reqModule,
  input  wire logic [26:0] reqAddr,
  input  wire logic [5:0]  reqLen,
  output logic             reqError,
  output logic             dataValid,
  input  wire logic        dataReady,
  output logic      [7:0]  dataByte,
  output logic             bootDone,
  output logic             descValid,
  output logic      [1:0]  addrWide
);
  typedef struct packed {
    sfr_pkg::sfr_state_t st;
    sfr_pkg::sfr_job_t   job;
    logic [3:0]          s1;
    logic [3:0]          s2;
    logic                sck;
    logic [2:0]          cs_n;
    logic [2:0]          div;
    logic [2:0]          half;
    logic [5:0]          clks;
    logic [1:0]          lanes;
    logic [1:0]          aLanes;
    logic [1:0]          dLanes;
    logic [5:0]          aBits;
    logic [3:0]          dummy;
    logic [31:0]         outSh;
    logic [31:0]         txAddr;
    logic [7:0]          inSh;
    logic [6:0]          left;
    logic [6:0]          byteIdx;
    logic [31:0]         word;
    logic                sigOk;
    logic                descOk;
    logic                err;
    logic                push;
    logic [7:0]          pushByte;
    logic [1:0]          addr4;
    logic [3:0][14:0]    base;
    logic [3:0][14:0]    limit;
    logic [3:0]          pinOut;
    logic [3:0]          pinOe_n;
  } sfr_ctrl_t;
  localparam sfr_ctrl_t RST = '{st: sfr_pkg::ST_IDLE, job: sfr_pkg::JOB_SFDP0,
    cs_n: sfr_pkg::CS_IDLE, pinOe_n: sfr_pkg::OE_RELEASE, default: '0};
  sfr_ctrl_t   r;
  sfr_ctrl_t   n;
  logic [7:0]  inNext;
  logic [7:0]  cmd;
  logic [31:0] newWord;
  logic [27:0] lin;
  logic [27:0] limEnd;
  logic [27:0] c0Size;
  logic [27:0] c1Size;
  logic [27:0] compAddr;
  logic [2:0]  halfSel;
  logic [2:0]  mode;
  logic        refuse;
  logic        onPri;
  logic        wide;
  logic        go;
  logic        stall;
  logic        bufReady;
  // ==========================================================
  // Outputs
  assign serialFlashClock       = r.sck;
  assign flashSelectPrimary_n   = r.cs_n[0];
  assign flashSelectSecondary_n = r.cs_n[1];
  assign moduleSelect_n         = r.cs_n[2];
  assign ioOut                  = r.pinOut;
  assign ioOe_n                 = r.pinOe_n;
  assign reqError               = r.err;
  assign bootDone               = (r.job == sfr_pkg::JOB_RUN);
  assign descValid              = r.descOk;
  assign addrWide               = r.addr4;
  assign reqReady = (r.st == sfr_pkg::ST_IDLE) && (r.job == sfr_pkg::JOB_RUN);
  // Read data buffer; a full buffer stalls the serial clock between bytes
  sfr_buf2 #(.WIDTH(8), .DEPTH(2)) uBuf (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .inValid  (r.push),
    .inReady  (bufReady),
    .inData   (r.pushByte),
    .outValid (dataValid),
    .outReady (dataReady),
    .outData  (dataByte)
  );
  // ==========================================================
  // Request decode: region window and component split
  always_comb begin
    mode    = (readMode > sfr_pkg::MODE_LAST) ? 3'h0 : readMode;
    halfSel = (rateSel > sfr_pkg::MODE_LAST) ? sfr_pkg::SCK_HALF[0] : sfr_pkg::SCK_HALF[rateSel]; // RULE_05
    lin     = {1'b0, r.base[reqId], 12'h000} + {1'b0, reqAddr}; // RULE_12
    limEnd  = {1'b0, r.limit[reqId], sfr_pkg::RGN_UNIT_MASK};
    c0Size  = r.addr4[0] ? sfr_pkg::COMP_SIZE4 : sfr_pkg::COMP_SIZE3; // RULE_02 RULE_03
    c1Size  = r.addr4[1] ? sfr_pkg::COMP_SIZE4 : sfr_pkg::COMP_SIZE3;
    onPri   = (lin < c0Size);
    compAddr = onPri ? lin : lin - c0Size; // RULE_13
    wide    = onPri ? r.addr4[0] : r.addr4[1];
    // Base, limit and part bounds of the requester's own region
    refuse  = !r.descOk || (r.base[reqId] > r.limit[reqId]) || (lin > limEnd) // RULE_08 RULE_19 RULE_21
              || (!onPri && compAddr >= c1Size);
  end
  // ==========================================================
  // Sequencer next state
  always_comb begin
    n = r;
    n.s1 = ioIn;
    n.s2 = r.s1;
    n.err = 1'b0;
    n.push = 1'b0;
    go = 1'b0;
    stall = 1'b0;
    cmd = sfr_pkg::CMD_SFDP;
    case (r.lanes)
      2'h0:    inNext = {r.inSh[6:0], r.s2[1]};
      2'h1:    inNext = {r.inSh[5:0], r.s2[1:0]};
      default: inNext = {r.inSh[3:0], r.s2};
    endcase
    newWord = {inNext, r.word[31:8]};
    case (r.st)
      sfr_pkg::ST_IDLE: begin
        n.aBits = sfr_pkg::ADDR_BITS3;
        n.aLanes = 2'h0;
        n.dLanes = 2'h0;
        n.dummy = sfr_pkg::DUMMY[0];
        if (r.job != sfr_pkg::JOB_RUN) begin
          // Discovery of both parts, then descriptor from the primary part
          go = 1'b1;
          n.cs_n = (r.job == sfr_pkg::JOB_SFDP1) ? sfr_pkg::CS_SEC : sfr_pkg::CS_PRI; // RULE_11 RULE_16
          cmd = (r.job == sfr_pkg::JOB_DESC) ? sfr_pkg::CMD3[0] : sfr_pkg::CMD_SFDP;
          n.txAddr = {(r.job == sfr_pkg::JOB_DESC) ? sfr_pkg::DESC_SIG_OFF : sfr_pkg::SFDP_ADDR, 8'h00};
          n.left = (r.job == sfr_pkg::JOB_DESC) ? sfr_pkg::DESC_READ_LEN : 7'h01; // RULE_18
        end else if (reqValid && reqModule) begin
          // Module read: same clock and data lines, third select
          go = 1'b1;
          n.cs_n = sfr_pkg::CS_MOD; // RULE_07
          cmd = {sfr_pkg::MOD_READ, reqLen};
          n.txAddr = {reqAddr[23:0], 8'h00};
          n.dummy = 4'h0;
          n.left = {1'b0, reqLen} + 7'h01;
        end else if (reqValid && refuse) begin
          n.err = 1'b1; // RULE_21
        end else if (reqValid) begin
          go = 1'b1;
          n.cs_n = onPri ? sfr_pkg::CS_PRI : sfr_pkg::CS_SEC; // RULE_01 RULE_13
          cmd = wide ? sfr_pkg::CMD4[mode] : sfr_pkg::CMD3[mode]; // RULE_06
          n.txAddr = wide ? {4'h0, compAddr} : {compAddr[23:0], 8'h00};
          n.aBits = wide ? sfr_pkg::ADDR_BITS4 : sfr_pkg::ADDR_BITS3; // RULE_04
          n.aLanes = sfr_pkg::ADDR_LANES[mode];
          n.dLanes = sfr_pkg::DATA_LANES[mode];
          n.dummy = sfr_pkg::DUMMY[mode];
          n.left = {1'b0, reqLen} + 7'h01;
        end
        if (go) begin
          n.st = sfr_pkg::ST_CMD;
          n.outSh = {cmd, 24'h000000};
          n.lanes = 2'h0;
          n.clks = sfr_pkg::CMD_BITS;
          n.half = halfSel;
          n.div = halfSel;
          n.sck = 1'b0;
          n.byteIdx = 7'h00;
        end
      end
      sfr_pkg::ST_GAP: begin
        // Select high, clock low, then hand over to the next job
        if (r.div > 3'h1) begin
          n.div = r.div - 3'h1;
        end else begin
          n.st = sfr_pkg::ST_IDLE;
          case (r.job)
            sfr_pkg::JOB_SFDP0: n.job = sfr_pkg::JOB_SFDP1;
            sfr_pkg::JOB_SFDP1: n.job = sfr_pkg::JOB_DESC;
            sfr_pkg::JOB_DESC: begin
              n.job = sfr_pkg::JOB_RUN;
              n.descOk = r.sigOk; // RULE_08 RULE_17
            end
            default: n.job = sfr_pkg::JOB_RUN;
          endcase
        end
      end
      default: begin
        stall = (r.st == sfr_pkg::ST_DATA) && !r.sck && (r.job == sfr_pkg::JOB_RUN)
                && (r.clks == (sfr_pkg::CMD_BITS >> r.dLanes)) && !bufReady;
        if (r.div > 3'h1) begin
          n.div = r.div - 3'h1;
        end else if (!stall) begin
          n.div = r.half;
          n.sck = !r.sck;
          if (r.sck) begin
            // Falling edge: sample, shift, count clocks of the phase
            n.inSh = inNext;
            n.outSh = r.outSh << (3'h1 << r.lanes);
            n.clks = r.clks - 6'h01;
            if (r.clks == 6'h01) begin
              case (r.st)
                sfr_pkg::ST_CMD: begin
                  n.st = sfr_pkg::ST_ADDR;
                  n.outSh = r.txAddr;
                  n.lanes = r.aLanes;
                  n.clks = r.aBits >> r.aLanes;
                end
                sfr_pkg::ST_ADDR, sfr_pkg::ST_DUMMY: begin
                  if (r.st == sfr_pkg::ST_ADDR && r.dummy != 4'h0) begin
                    n.st = sfr_pkg::ST_DUMMY;
                    n.clks = {2'h0, r.dummy};
                  end else begin
                    n.st = sfr_pkg::ST_DATA;
                    n.lanes = r.dLanes;
                    n.clks = sfr_pkg::CMD_BITS >> r.dLanes;
                  end
                end
                default: begin
                  // One byte complete
                  n.left = r.left - 7'h01;
                  n.byteIdx = r.byteIdx + 7'h01;
                  n.clks = sfr_pkg::CMD_BITS >> r.dLanes;
                  n.word = newWord;
                  case (r.job)
                    sfr_pkg::JOB_SFDP0: n.addr4[0] = inNext[sfr_pkg::ADDR_MODE_LSB+1] ^ inNext[sfr_pkg::ADDR_MODE_LSB]; // RULE_04
                    sfr_pkg::JOB_SFDP1: n.addr4[1] = inNext[sfr_pkg::ADDR_MODE_LSB+1] ^ inNext[sfr_pkg::ADDR_MODE_LSB];
                    sfr_pkg::JOB_DESC: begin
                      if (r.byteIdx == 7'h03) n.sigOk = (newWord == sfr_pkg::DESC_SIG); // RULE_17
                      for (int k = 0; k < 4; k++) begin
                        if (r.byteIdx == 7'((sfr_pkg::DESC_RGN_OFF - 'h10) + 4 * sfr_pkg::REQ_RGN[k] + 3)) begin
                          n.base[k] = newWord[14:0]; // RULE_09 RULE_10 RULE_12
                          n.limit[k] = newWord[sfr_pkg::RGN_LIMIT_LSB +: 15];
                        end
                      end
                    end
                    default: begin
                      n.push = 1'b1;
                      n.pushByte = inNext;
                    end
                  endcase
                  if (r.left == 7'h01) begin
                    n.st = sfr_pkg::ST_GAP;
                    n.cs_n = sfr_pkg::CS_IDLE; // RULE_20
                  end
                end
              endcase
            end
          end
        end
      end
    endcase
    // Drive the lines of the command and address phases
    n.pinOe_n = sfr_pkg::OE_RELEASE;
    n.pinOut = 4'h0;
    if (n.st == sfr_pkg::ST_CMD || n.st == sfr_pkg::ST_ADDR) begin
      case (n.lanes)
        2'h0:    begin n.pinOe_n = 4'hE; n.pinOut = {3'h0, n.outSh[31]}; end
        2'h1:    begin n.pinOe_n = 4'hC; n.pinOut = {2'h0, n.outSh[31:30]}; end
        default: begin n.pinOe_n = 4'h0; n.pinOut = n.outSh[31:28]; end
      endcase
    end
  end
  // State register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) r <= RST;
    else r <= n;
  end
  // ==========================================================
  // Assertions
  a_one_select: // RULE_01
    assert property (@(posedge ref_clk) disable iff (!rst_n) $onehot0(~r.cs_n))
      else $error("two selects active");
  a_clock_idle: // RULE_20
    assert property (@(posedge ref_clk) disable iff (!rst_n) (&r.cs_n) |-> !r.sck)
      else $error("clock toggles without select");
  a_module_run: // RULE_07
    assert property (@(posedge ref_clk) disable iff (!rst_n) $fell(moduleSelect_n) |-> $past(reqModule && reqValid))
      else $error("module select without module request");
  a_desc_gate: // RULE_08
    assert property (@(posedge ref_clk) disable iff (!rst_n)
      (reqValid && reqReady && !reqModule && !r.descOk) |=> reqError && (&r.cs_n))
      else $error("flash read without valid descriptor");
  a_refuse_hold: // RULE_21
    assert property (@(posedge ref_clk) disable iff (!rst_n) reqError |-> ##1 (&r.cs_n) && reqReady)
      else $error("refused read opened a select");
  a_sig_source: // RULE_17
    assert property (@(posedge ref_clk) disable iff (!rst_n) $rose(descValid) |-> $past(r.sigOk) && bootDone)
      else $error("descriptor valid without signature");
  a_boot_primary: // RULE_16
    assert property (@(posedge ref_clk) disable iff (!rst_n) (r.job == sfr_pkg::JOB_DESC) |-> r.cs_n[1] && r.cs_n[2])
      else $error("descriptor read off primary part");
  a_desc_window: // RULE_18
    assert property (@(posedge ref_clk) disable iff (!rst_n)
      (r.job == sfr_pkg::JOB_DESC) |-> (32'(r.byteIdx) + 32'(sfr_pkg::DESC_SIG_OFF) < sfr_pkg::DESC_MAX))
      else $error("descriptor read beyond first 4 KB");
  a_clock_high: // RULE_05
    assert property (@(posedge ref_clk) disable iff (!rst_n) $rose(r.sck) |-> r.sck ##1 r.sck)
      else $error("serial clock high too short");
  a_push_room:
    assert property (@(posedge ref_clk) disable iff (!rst_n) r.push |-> bufReady)
      else $error("byte pushed into full buffer");
endmodule // sfr_region_ctrl

// [hdl/sfr_pkg.sv]
// sfr_pkg: constants, tables and state encodings of the region controller.
// Assumes a 100 MHz ref_clk; used by the controller and its assertions, not by the tests.
package sfr_pkg;
  // ==========================================================
  // Serial clock
  localparam int CLK_MHZ      = 100;
  localparam int SCK_HALF_MIN = 2;
  localparam int SCK_MHZ [0:4] = '{14, 25, 33, 50, 100};
  // Half period in ref_clk cycles, rounded up, never below the sync depth
  function automatic logic [2:0] sckHalf(input int mhz);
    int h;
    h = (CLK_MHZ + 2 * mhz - 1) / (2 * mhz);
    if (h < SCK_HALF_MIN) h = SCK_HALF_MIN;
    return 3'(h);
  endfunction
  localparam logic [2:0] SCK_HALF [0:4] = '{sckHalf(SCK_MHZ[0]), sckHalf(SCK_MHZ[1]),
    sckHalf(SCK_MHZ[2]), sckHalf(SCK_MHZ[3]), sckHalf(SCK_MHZ[4])};
  // ==========================================================
  // Commands per read mode: fast, dual out, dual io, quad out, quad io
  localparam logic [2:0] MODE_LAST = 3'h4;
  localparam logic [7:0] CMD3 [0:4] = '{8'h0B, 8'h3B, 8'hBB, 8'h6B, 8'hEB};
  localparam logic [7:0] CMD4 [0:4] = '{8'h0C, 8'h3C, 8'hBC, 8'h6C, 8'hEC};
  localparam logic [3:0] DUMMY [0:4] = '{4'h8, 4'h8, 4'h4, 4'h8, 4'h6};
  localparam logic [1:0] ADDR_LANES [0:4] = '{2'h0, 2'h0, 2'h1, 2'h0, 2'h2};
  localparam logic [1:0] DATA_LANES [0:4] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2};
  localparam logic [7:0] CMD_SFDP   = 8'h5A;
  localparam logic [1:0] MOD_READ   = 2'h2;
  localparam logic [5:0] CMD_BITS   = 6'h08;
  localparam logic [5:0] ADDR_BITS3 = 6'h18;
  localparam logic [5:0] ADDR_BITS4 = 6'h20;
  // ==========================================================
  // Discovery and descriptor layout
  localparam logic [23:0] SFDP_ADDR     = 24'h000032;
  localparam int          ADDR_MODE_LSB = 1;
  localparam logic [23:0] DESC_SIG_OFF  = 24'h000010;
  localparam int          DESC_RGN_OFF  = 'h40;
  localparam logic [31:0] DESC_SIG      = 32'h0FF0A55A;
  localparam int          DESC_MAX      = 4096;
  localparam int          RGN_LIMIT_LSB = 16;
  localparam logic [11:0] RGN_UNIT_MASK = 12'hFFF;
  // Region numbers
  localparam int RGN_DESC = 0;
  localparam int RGN_BOOT = 1;
  localparam int RGN_MGMT = 2;
  localparam int RGN_NET  = 3;
  localparam int RGN_PLAT = 4;
  localparam int RGN_EC   = 8;
  localparam int RGN_SEC  = 10;
  // Requesters: host, network, management engine, embedded controller
  localparam int REQ_RGN [0:3] = '{RGN_BOOT, RGN_NET, RGN_MGMT, RGN_EC};
  localparam logic [6:0] DESC_READ_LEN = 7'(((DESC_RGN_OFF - 'h10) / 4 + RGN_EC + 1) * 4);
  // ==========================================================
  // Component sizes and reset values
  localparam logic [27:0] COMP_SIZE3 = 28'h1000000;
  localparam logic [27:0] COMP_SIZE4 = 28'h4000000;
  localparam logic [2:0]  CS_IDLE    = 3'h7;
  localparam logic [2:0]  CS_PRI     = 3'h6;
  localparam logic [2:0]  CS_SEC     = 3'h5;
  localparam logic [2:0]  CS_MOD     = 3'h3;
  localparam logic [3:0]  OE_RELEASE = 4'hF;
  typedef enum logic [5:0] {ST_IDLE = 6'h01, ST_CMD = 6'h02, ST_ADDR = 6'h04,
    ST_DUMMY = 6'h08, ST_DATA = 6'h10, ST_GAP = 6'h20} sfr_state_t;
  typedef enum logic [3:0] {JOB_SFDP0 = 4'h1, JOB_SFDP1 = 4'h2, JOB_DESC = 4'h4,
    JOB_RUN = 4'h8} sfr_job_t;
endpackage

// [hdl/sfr_buf2.sv]
// sfr_buf2: small FIFO with valid and ready on both sides.
// Assumes one clock; the filler must hold off while inReady is low.
`timescale 1ns/10ps
module sfr_buf2 #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW:0]                 cnt;
    logic [PW-1:0]               rp;
  } sfr_buf_t;
  sfr_buf_t      r;
  sfr_buf_t      n;
  logic          push;
  logic          pop;
  logic [PW-1:0] wp;
  // ==========================================================
  // Handshakes
  assign inReady  = (r.cnt != (PW+1)'(DEPTH));
  assign outValid = (r.cnt != '0);
  assign outData  = r.mem[r.rp];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;
  // Next state: write behind the read pointer, wrap at depth
  always_comb begin
    n  = r;
    wp = PW'((32'(r.rp) + 32'(r.cnt)) % DEPTH);
    if (push) n.mem[wp] = inData;
    if (pop) n.rp = (r.rp == PW'(DEPTH - 1)) ? '0 : r.rp + 1'b1;
    n.cnt = r.cnt + (PW+1)'(push) - (PW+1)'(pop);
  end
  // State register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) r <= '0;
    else r <= n;
  end
  a_buf_bound:
    assert property (@(posedge ref_clk) disable iff (!rst_n) r.cnt <= (PW+1)'(DEPTH))
      else $error("buffer count above depth");
endmodule // sfr_buf2

// [testbench/sfr_img.svh]
// sfr_img: flash image content shared by the partner model and the bench.
// Assumes inclusion inside a module body; one region word per 4-byte slot at 0x40.
// Image bytes: 3-byte part, signature, regions of one block, network two
function automatic logic [7:0] sfr_img(input logic [23:0] a);
  logic [7:0] base;
  logic [7:0] lim;
  base = 8'hFF;
  lim  = 8'hFF;
  if (a == 24'h000032) return 8'h00;
  if (a[23:2] == 22'h000004) return 8'(32'h0FF0A55A >> (8 * a[1:0]));
  if (a[23:6] == 18'h00001) begin
    case (a[5:2])
      4'h1: {base, lim} = {8'h02, 8'h02};
      4'h2: {base, lim} = {8'h03, 8'h03};
      4'h3: {base, lim} = {8'h04, 8'h05};
      4'h8: {base, lim} = {8'h06, 8'h06};
      default: ;
    endcase
    if (a[1:0] == 2'h0) return base;
    if (a[1:0] == 2'h2) return lim;
    return (base == 8'hFF) ? 8'hFF : 8'h00;
  end
  return a[7:0] ^ a[15:8] ^ 8'h3C;
endfunction

// [testbench/sfr_flash_model.sv]
// sfr_flash_model: behavioural flash on the primary select plus module on the third.
// Assumes mode 0 clock from the controller, address on one, two or four lanes, pull-ups outside.
`timescale 1ns/10ps
module sfr_flash_model (
  input  wire logic       sck,
  input  wire logic       selPri_n,
  input  wire logic       selMod_n,
  input  wire logic [3:0] io,
  output logic      [3:0] ioDrv,
  output logic      [3:0] ioEn
);
`include "sfr_img.svh"
  logic [7:0]  cmd;
  logic [23:0] addr;
  logic [7:0]  sh;
  int          cnt;
  int          lanes;
  int          start;
  int          k;
  logic [3:0]  en;
  wire         sel    = !selPri_n || !selMod_n;
  wire         dualIo = (cmd == 8'hBB);
  wire         quadIo = (cmd == 8'hEB);
  // Lines released as soon as the select rises, whatever the last clock edge did
  assign ioEn = sel ? en : 4'h0;
  // Frame start clears the clock count and the drive enables
  always @(posedge sel) begin
    cnt = 0;
    en  = 4'h0;
  end
  // Command and address shifted in on rising clock
  always @(posedge sck) if (sel) begin
    cnt = cnt + 1;
    if (cnt <= 8) cmd = {cmd[6:0], io[0]};
    else if (dualIo && cnt <= 20) addr = {addr[21:0], io[1:0]};
    else if (quadIo && cnt <= 14) addr = {addr[19:0], io};
    else if (!dualIo && !quadIo && cnt <= 32) addr = {addr[22:0], io[0]};
  end
  // Data driven on falling clock, MSB first, lanes from the command
  always @(negedge sck) if (sel) begin
    lanes = (cmd == 8'h3B || dualIo) ? 2 : (cmd == 8'h6B || quadIo) ? 4 : 1;
    start = !selMod_n ? 32 : dualIo ? 24 : quadIo ? 20 : 40;
    if (cnt >= start) begin
      k     = cnt - start;
      sh    = sfr_img(addr + 24'(k * lanes / 8)) << ((k % (8 / lanes)) * lanes);
      ioDrv = (lanes == 1) ? {2'h0, sh[7], 1'b0} : (lanes == 2) ? {2'h0, sh[7:6]} : sh[7:4];
      en    = (lanes == 1) ? 4'h2 : (lanes == 2) ? 4'h3 : 4'hF;
    end
  end
endmodule // sfr_flash_model

// [testbench/tb_top.sv]
// tb_top: self-checking bench of the region controller with its flash partner.
// Assumes 100 MHz ref_clk, pull-ups on the io lines, image from sfr_img.
`timescale 1ns/10ps
module tb_top;
`include "sfr_img.svh"
  logic        ref_clk, rst_n, sck, selPri_n, selSec_n, selMod_n;
  logic [3:0]  ioOut, ioOe_n, ioDrv, ioEn, ioLine;
  logic [2:0]  rateSel, readMode;
  logic        reqValid, reqReady, reqModule, reqError, dataValid, dataReady;
  logic [1:0]  reqId, addrWide;
  logic [26:0] reqAddr;
  logic [5:0]  reqLen;
  logic [7:0]  dataByte;
  logic        bootDone, descValid;
  int          error_cnt = 0;
  int          tests_run = 0;
  int          i;
  // Wire level: controller, then flash, else pull-up
  always_comb for (int b = 0; b < 4; b++) ioLine[b] = !ioOe_n[b] ? ioOut[b] : ioEn[b] ? ioDrv[b] : 1'b1;
  sfr_region_ctrl DUT (.ref_clk(ref_clk), .rst_n(rst_n), .serialFlashClock(sck),
    .flashSelectPrimary_n(selPri_n), .flashSelectSecondary_n(selSec_n), .moduleSelect_n(selMod_n),
    .ioIn(ioLine), .ioOut(ioOut), .ioOe_n(ioOe_n), .rateSel(rateSel), .readMode(readMode),
    .reqValid(reqValid), .reqReady(reqReady), .reqId(reqId), .reqModule(reqModule), .reqAddr(reqAddr),
    .reqLen(reqLen), .reqError(reqError), .dataValid(dataValid), .dataReady(dataReady),
    .dataByte(dataByte), .bootDone(bootDone), .descValid(descValid), .addrWide(addrWide));
  sfr_flash_model flashModel (.sck(sck), .selPri_n(selPri_n), .selMod_n(selMod_n), .io(ioLine),
    .ioDrv(ioDrv), .ioEn(ioEn));
  // ==========================================================
  // Clock, compare, verdict
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Selects one at a time, clock idle low when none is active
  always @(negedge ref_clk) if (rst_n) begin
    check({selPri_n, selSec_n, selMod_n} inside {3'h7, 3'h6, 3'h5, 3'h3}, 1'b1);
    if ({selPri_n, selSec_n, selMod_n} == 3'h7) check(sck, 1'b0);
  end
  // ==========================================================
  // One read request: issue, collect bytes with optional stall, judge
  task automatic doRead(input logic [1:0] id, input logic mdl, input logic [26:0] off, input logic [5:0] len,
                        input logic [2:0] mode, input logic [2:0] rate, input logic stall, input logic expErr,
                        input logic [23:0] lin);
    int   n, w;
    logic gotErr, sawPri, sawMod;
    n = 0;
    gotErr = 1'b0;
    sawPri = 1'b0;
    sawMod = 1'b0;
    @(posedge ref_clk);
    {reqValid, reqId, reqModule, reqAddr, reqLen, readMode, rateSel} <= {1'b1, id, mdl, off, len, mode, rate};
    @(negedge ref_clk);
    for (w = 0; w < 5000 && reqReady !== 1'b1; w++) @(negedge ref_clk);
    @(posedge ref_clk);
    reqValid <= 1'b0;
    for (w = 0; w < 20000 && n <= len && !gotErr; w++) begin
      @(negedge ref_clk);
      if (reqError === 1'b1) gotErr = 1'b1;
      if (selPri_n === 1'b0) sawPri = 1'b1;
      if (selMod_n === 1'b0) sawMod = 1'b1;
      if (dataValid === 1'b1 && dataReady === 1'b1) begin
        check(dataByte, sfr_img(lin + 24'(n)));
        n++;
      end
      @(posedge ref_clk);
      dataReady <= !stall || (w % 64 >= 32);
    end
    check(gotErr, expErr);
    check(n, expErr ? 0 : len + 1);
    check(sawMod, mdl && !expErr);
    check(sawPri, !mdl && !expErr);
  endtask
  initial begin
    #400000;
    error_cnt++;
    stop_test();
  end
  // ==========================================================
  // Main sequence
  initial begin
    {rst_n, reqValid, dataReady, rateSel, readMode} = {1'b0, 1'b0, 1'b1, 3'h4, 3'h0};
    {reqId, reqModule, reqAddr, reqLen} = '0;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    check({selPri_n, selSec_n, selMod_n, sck, ioOe_n, bootDone}, {3'h7, 1'b0, 4'hF, 1'b0});
    @(posedge ref_clk);
    rst_n <= 1'b1;
    for (i = 0; i < 20000 && bootDone !== 1'b1; i++) @(negedge ref_clk);
    check(descValid, 1'b1);
    check(addrWide, 2'h0);
    doRead(2'h0, 1'b0, 27'h0000000, 6'h3F, 3'h0, 3'h0, 1'b1, 1'b0, 24'h002000);
    doRead(2'h1, 1'b0, 27'h0001FC0, 6'h3F, 3'h1, 3'h2, 1'b0, 1'b0, 24'h005FC0);
    doRead(2'h2, 1'b0, 27'h0000010, 6'h07, 3'h3, 3'h3, 1'b1, 1'b0, 24'h003010);
    doRead(2'h3, 1'b0, 27'h0000020, 6'h00, 3'h0, 3'h4, 1'b0, 1'b0, 24'h006020);
    doRead(2'h2, 1'b0, 27'h0000100, 6'h03, 3'h2, 3'h1, 1'b0, 1'b0, 24'h003100);
    doRead(2'h3, 1'b0, 27'h0000200, 6'h03, 3'h4, 3'h3, 1'b1, 1'b0, 24'h006200);
    doRead(2'h0, 1'b1, 27'h0123456, 6'h05, 3'h0, 3'h1, 1'b0, 1'b0, 24'h123456);
    doRead(2'h0, 1'b0, 27'h0001000, 6'h00, 3'h0, 3'h4, 1'b0, 1'b1, 24'h000000);
    doRead(2'h1, 1'b0, 27'h0002000, 6'h00, 3'h0, 3'h4, 1'b0, 1'b1, 24'h000000);
    stop_test();
  end
endmodule // tb_top
